// File: hdl/ebp_pkg.sv
// Package: register map, field layouts, modes and states for the encoder boot/position block.
// Assumes one 250 MHz system clock and a single register write/read port.
package ebp_pkg;
  localparam int          REG_AW              = 3;
  localparam logic [2:0]  ADDR_IFACE_DIR      = 3'h0;
  localparam logic [2:0]  ADDR_PHASE_OFFSET   = 3'h1;
  localparam logic [2:0]  ADDR_PERIODS_REV    = 3'h2;
  localparam logic [2:0]  ADDR_SCANNING       = 3'h4;
  localparam logic [2:0]  ADDR_OUTPUT_OPTIONS = 3'h5;
  localparam int          BIT_SERIAL_CHOICE   = 0;
  localparam int          BIT_COUNT_DIR       = 3;
  localparam int          OS_MSB              = 7;
  localparam int          OS_LSB              = 5;
  localparam int          BIT_ON_AXIS         = 2;
  localparam int          POLE_MSB            = 1;
  localparam int          BIT_PERIOD_INDEX    = 6;
  localparam logic [7:0]  CFG_RESET           = 8'h00;
  localparam logic [6:0]  SLAVE_ADDR          = 7'h61;
  localparam logic [1:0]  POLE_DIFF_1_3       = 2'h0;
  localparam logic [1:0]  POLE_SE_4_5         = 2'h1;
  localparam logic [1:0]  POLE_SE_2_4         = 2'h2;
  localparam logic [1:0]  POLE_SE_1_3         = 2'h3;
  localparam logic [1:0]  RETRY_LIMIT         = 2'h3;
  localparam int          MT_WIDTH            = 40;
  localparam int          MT_LIMITED          = 32;
  localparam int          IDX_WIDTH           = 8;
  localparam int          EE_BYTES            = 6;
  typedef enum logic [1:0] {
    MODE_SERIAL   = 2'h0,
    MODE_CHAIN    = 2'h1,
    MODE_SLAVE    = 2'h3,
    MODE_PARALLEL = 2'h2
  } ebp_mode_t;
  typedef enum logic [2:0] {
    ST_POWERON = 3'h0,
    ST_EEREAD  = 3'h1,
    ST_RUN     = 3'h3,
    ST_ERROR   = 3'h2,
    ST_IDLE    = 3'h6
  } ebp_state_t;
endpackage : ebp_pkg

// File: hdl/ebp_cfg_if.sv
// Interface: configuration fields passed from the top to the position processor.
// Assumes both ends share clk_sys_in.
interface ebp_cfg_if;
  logic [2:0] phase_offset;
  logic       count_dir;
  logic [2:0] position;
  modport ctrl (output phase_offset, output count_dir, input position);
  modport proc (input phase_offset, input count_dir, output position);
endinterface : ebp_cfg_if

// File: hdl/ebp_position.sv
// Position processor: direction correction and phase offset on the 3-bit Hall word.
// Assumes the Hall word is already synchronised to clk_sys_in.
module ebp_position
  import ebp_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic [2:0] hall_in,
  ebp_cfg_if.proc         cfg
);
  logic [2:0] dir_pos;
  logic [2:0] pos_reg;
  always_comb begin
    dir_pos = cfg.count_dir ? 3'(3'h0 - hall_in) : hall_in;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_reg <= 3'h0;
    end else begin
      pos_reg <= 3'(dir_pos + cfg.phase_offset);
    end
  end
  assign cfg.position = pos_reg;
endmodule : ebp_position

// File: hdl/ebp_top.sv
// Top: startup sequencer, mode select, configuration registers, period counting.
// Assumes an outside EEPROM reader answers each byte request; pins pass 3-flop sync.
module ebp_top
  import ebp_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                reset_n_in,
  input  wire logic                sel_high_in,
  input  wire logic                sel_tied_preset_in,
  input  wire logic                preset_in,
  input  wire logic [2:0]          hall_in,
  input  wire logic                reg_wr_in,
  input  wire logic [REG_AW-1:0]   reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  output logic      [7:0]          reg_rdata_out,
  input  wire logic                status_clear_command_in,
  input  wire logic                battery_error_in,
  output logic                     battery_error_out,
  output logic                     ee_req_out,
  output logic      [REG_AW-1:0]   ee_addr_out,
  input  wire logic                ee_done_in,
  input  wire logic                ee_fail_in,
  input  wire logic [7:0]          ee_data_in,
  input  wire logic                readout_done_in,
  output logic                     error_output_n_out,
  output logic      [1:0]          mode_out,
  output logic                     serial_readout_out,
  output logic                     twowire_readout_out,
  output logic      [6:0]          slave_addr_out,
  output logic                     slave_enable_out,
  output logic                     low_power_idle_out,
  output logic                     scan_differential_out,
  output logic                     scan_on_axis_out,
  output logic      [1:0]          pole_size_select_out,
  output logic      [2:0]          position_out,
  output logic      [2:0]          parallel_p_out,
  output logic      [2:0]          parallel_n_out,
  output logic      [MT_WIDTH-1:0] multiturn_out
);
  logic [2:0] pre_sync_reg;
  logic [2:0] selh_sync_reg;
  logic [2:0] selp_sync_reg;
  logic       pre_level_reg;
  logic       selh_level_reg;
  logic       selp_level_reg;
  logic       pre_rise;
  logic [7:0] iface_dir_reg;
  logic [7:0] phase_offset_reg;
  logic [7:0] periods_per_revolution_reg;
  logic [7:0] scanning_reg;
  logic [7:0] output_options_reg;
  ebp_state_t state_reg;
  ebp_mode_t  mode_reg;
  logic [1:0] fail_count_reg;
  logic [REG_AW-1:0] ee_idx_reg;
  logic       ee_req_reg;
  logic       twowire_pos_reg;
  logic       bat_err_reg;
  logic [2:0] hall_s1_reg;
  logic [2:0] hall_s2_reg;
  logic [2:0] hall_s3_reg;
  logic [2:0] hall_sync_reg;
  logic [2:0] pos_prev_reg;
  logic [IDX_WIDTH-1:0] period_idx_reg;
  logic [MT_WIDTH-1:0]  mt_count_reg;
  logic       step_up;
  logic       step_down;
  logic       started;
  logic       ee_wr;
  logic [REG_AW-1:0] wr_addr;
  logic [7:0] wr_data;

  ebp_cfg_if cfg ();

  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_sync_reg  <= 3'h0;
      selh_sync_reg <= 3'h0;
      selp_sync_reg <= 3'h0;
      pre_level_reg <= 1'b0;
      selh_level_reg <= 1'b0;
      selp_level_reg <= 1'b0;
    end else begin
      pre_sync_reg  <= {pre_sync_reg[1:0], preset_in};
      selh_sync_reg <= {selh_sync_reg[1:0], sel_high_in};
      selp_sync_reg <= {selp_sync_reg[1:0], sel_tied_preset_in};
      if (pre_sync_reg[1] == pre_sync_reg[2]) begin
        pre_level_reg <= pre_sync_reg[2];
      end
      if (selh_sync_reg[1] == selh_sync_reg[2]) begin
        selh_level_reg <= selh_sync_reg[2];
      end
      if (selp_sync_reg[1] == selp_sync_reg[2]) begin
        selp_level_reg <= selp_sync_reg[2];
      end
    end
  end
  assign pre_rise = (pre_sync_reg[1] == pre_sync_reg[2]) && pre_sync_reg[2] && !pre_level_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hall_s1_reg   <= 3'h0;
      hall_s2_reg   <= 3'h0;
      hall_s3_reg   <= 3'h0;
      hall_sync_reg <= 3'h0;
    end else begin
      hall_s1_reg <= hall_in;
      hall_s2_reg <= hall_s1_reg;
      hall_s3_reg <= hall_s2_reg;
      if (hall_s2_reg == hall_s3_reg) begin
        hall_sync_reg <= hall_s3_reg;
      end
    end
  end

  // Register writes from the register port or from the EEPROM boot read
  assign ee_wr   = (state_reg == ST_EEREAD) && ee_done_in && !ee_fail_in;
  assign wr_addr = ee_wr ? ee_idx_reg : reg_addr_in;
  assign wr_data = ee_wr ? ee_data_in : reg_wdata_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      iface_dir_reg              <= CFG_RESET;
      phase_offset_reg           <= CFG_RESET;
      periods_per_revolution_reg <= CFG_RESET;
      scanning_reg               <= CFG_RESET;
      output_options_reg         <= CFG_RESET;
    end else if (ee_wr || reg_wr_in) begin
      if (wr_addr == ADDR_IFACE_DIR) begin
        iface_dir_reg <= wr_data;
      end else if (wr_addr == ADDR_PHASE_OFFSET) begin
        phase_offset_reg <= wr_data;
      end else if (wr_addr == ADDR_PERIODS_REV) begin
        periods_per_revolution_reg <= wr_data;
      end else if (wr_addr == ADDR_SCANNING) begin
        scanning_reg <= wr_data;
      end else if (wr_addr == ADDR_OUTPUT_OPTIONS) begin
        output_options_reg <= wr_data;
      end
    end
  end

  always_comb begin
    if (reg_addr_in == ADDR_IFACE_DIR) begin
      reg_rdata_out = iface_dir_reg;
    end else if (reg_addr_in == ADDR_PHASE_OFFSET) begin
      reg_rdata_out = phase_offset_reg;
    end else if (reg_addr_in == ADDR_PERIODS_REV) begin
      reg_rdata_out = periods_per_revolution_reg;
    end else if (reg_addr_in == ADDR_SCANNING) begin
      reg_rdata_out = scanning_reg;
    end else if (reg_addr_in == ADDR_OUTPUT_OPTIONS) begin
      reg_rdata_out = output_options_reg;
    end else begin
      reg_rdata_out = 8'h00;
    end
  end

  // Startup sequencer
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg       <= ST_POWERON;
      mode_reg        <= MODE_SERIAL;
      fail_count_reg  <= 2'h0;
      ee_idx_reg      <= '0;
      ee_req_reg      <= 1'b0;
      twowire_pos_reg <= 1'b0;
    end else begin
      ee_req_reg <= 1'b0;
      case (state_reg)
        ST_POWERON: begin
          if (pre_rise) begin
            if (selp_level_reg) begin
              mode_reg        <= MODE_SLAVE;
              twowire_pos_reg <= 1'b1;
              state_reg       <= ST_RUN;
            end else if (selh_level_reg) begin
              mode_reg  <= MODE_PARALLEL;
              state_reg <= ST_RUN;
            end else begin
              mode_reg       <= MODE_SERIAL;
              fail_count_reg <= 2'h0;
              ee_idx_reg     <= '0;
              ee_req_reg     <= 1'b1;
              state_reg      <= ST_EEREAD;
            end
          end
        end
        ST_EEREAD: begin
          if (ee_done_in && ee_fail_in) begin
            if (fail_count_reg == RETRY_LIMIT - 2'h1) begin
              fail_count_reg <= RETRY_LIMIT;
              state_reg      <= ST_ERROR;
            end else begin
              fail_count_reg <= 2'(fail_count_reg + 2'h1);
              ee_idx_reg     <= '0;
              ee_req_reg     <= 1'b1;
            end
          end else if (ee_done_in) begin
            if (ee_idx_reg == REG_AW'(EE_BYTES - 1)) begin
              mode_reg  <= iface_dir_reg[BIT_SERIAL_CHOICE] ? MODE_CHAIN : MODE_SERIAL;
              state_reg <= ST_RUN;
            end else begin
              ee_idx_reg <= REG_AW'(ee_idx_reg + 1'b1);
              ee_req_reg <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (mode_reg == MODE_PARALLEL && readout_done_in) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (pre_rise) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_ERROR;
        end
      endcase
    end
  end

  assign started             = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
  assign ee_req_out          = ee_req_reg;
  assign ee_addr_out         = ee_idx_reg;
  assign error_output_n_out  = !(state_reg == ST_ERROR || bat_err_reg);
  assign mode_out            = mode_reg;
  assign low_power_idle_out  = (state_reg == ST_IDLE);
  assign slave_enable_out    = started && (mode_reg != MODE_PARALLEL) && (mode_reg != MODE_CHAIN);
  assign slave_addr_out      = SLAVE_ADDR;
  assign twowire_readout_out = started && twowire_pos_reg && mode_reg == MODE_SLAVE;
  assign serial_readout_out  = started && !twowire_pos_reg
                               && (mode_reg == MODE_SERIAL || mode_reg == MODE_CHAIN);

  // Battery error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bat_err_reg <= 1'b0;
    end else if (battery_error_in) begin
      bat_err_reg <= 1'b1;
    end else if (status_clear_command_in) begin
      bat_err_reg <= 1'b0;
    end
  end
  assign battery_error_out = bat_err_reg;

  // Scanning selection
  assign pole_size_select_out  = scanning_reg[POLE_MSB:0];
  assign scan_on_axis_out      = scanning_reg[BIT_ON_AXIS];
  assign scan_differential_out = scanning_reg[BIT_ON_AXIS]
                                 ? (scanning_reg[POLE_MSB:0] == POLE_SE_4_5)
                                 : (scanning_reg[POLE_MSB:0] == POLE_DIFF_1_3);

  // Position processing
  assign cfg.phase_offset = phase_offset_reg[OS_MSB:OS_LSB];
  assign cfg.count_dir    = iface_dir_reg[BIT_COUNT_DIR];

  ebp_position u_position (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .hall_in    (hall_sync_reg),
    .cfg        (cfg)
  );

  // Period and multiturn counting: wrap of the 3-bit word steps the period index
  assign step_up   = started && pos_prev_reg == 3'h7 && cfg.position == 3'h0;
  assign step_down = started && pos_prev_reg == 3'h0 && cfg.position == 3'h7;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_prev_reg   <= 3'h0;
      period_idx_reg <= '0;
      mt_count_reg   <= '0;
    end else begin
      pos_prev_reg <= cfg.position;
      if (step_up) begin
        if (period_idx_reg == periods_per_revolution_reg) begin
          period_idx_reg <= '0;
          mt_count_reg   <= MT_WIDTH'(mt_count_reg + 1'b1);
        end else begin
          period_idx_reg <= IDX_WIDTH'(period_idx_reg + 1'b1);
        end
      end else if (step_down) begin
        if (period_idx_reg == '0) begin
          period_idx_reg <= periods_per_revolution_reg;
          mt_count_reg   <= MT_WIDTH'(mt_count_reg - 1'b1);
        end else begin
          period_idx_reg <= IDX_WIDTH'(period_idx_reg - 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      multiturn_out  <= '0;
      position_out   <= 3'h0;
      parallel_p_out <= 3'h0;
      parallel_n_out <= 3'h7;
    end else begin
      if (output_options_reg[BIT_PERIOD_INDEX] && periods_per_revolution_reg != 8'h00) begin
        multiturn_out <= {mt_count_reg[MT_LIMITED-1:0], period_idx_reg};
      end else begin
        multiturn_out <= mt_count_reg;
      end
      // Sector within the revolution: (index*8+pos) over periods, no wide product
      position_out   <= 3'({period_idx_reg, cfg.position}
                        / ({3'h0, periods_per_revolution_reg} + 11'h001));
      parallel_p_out <= cfg.position;
      parallel_n_out <= ~cfg.position;
    end
  end
endmodule : ebp_top

// File: testbench/ebp_top_assertions.sv
// Checker: port-level relations of the encoder boot/position top.
// Bound onto every ebp_top instance; sees top ports only.
module ebp_top_assertions
  import ebp_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic       reg_wr_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       ee_done_in,
  input wire logic       status_clear_command_in,
  input wire logic       battery_error_in,
  input wire logic       battery_error_out,
  input wire logic       ee_req_out,
  input wire logic       error_output_n_out,
  input wire logic [1:0] mode_out,
  input wire logic       serial_readout_out,
  input wire logic       twowire_readout_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic       low_power_idle_out,
  input wire logic       scan_differential_out,
  input wire logic       scan_on_axis_out,
  input wire logic [1:0] pole_size_select_out,
  input wire logic [2:0] parallel_p_out,
  input wire logic [2:0] parallel_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  a_slave_addr: assert property (slave_addr_out == 7'h61)
    else $error("slave address wrong");
  a_par_compl: assert property (parallel_n_out == ~parallel_p_out)
    else $error("parallel pair not complementary");
  a_readout_excl: assert property (!(serial_readout_out && twowire_readout_out))
    else $error("readout routed both ways");
  a_batt_err: assert property ($rose(battery_error_out) |-> ##[0:2] !error_output_n_out)
    else $error("error pin not low on battery error");
  a_batt_clear: assert property ((status_clear_command_in && !battery_error_in) ##1
    !battery_error_in [*6] |-> !battery_error_out)
    else $error("battery flag not cleared");
  a_pole_echo: assert property (reg_wr_in && reg_addr_in == ADDR_SCANNING
    && !ee_done_in |=> pole_size_select_out == 2'($past(reg_wdata_in)))
    else $error("pole size output differs from written value");
  a_on_axis_enable_echo: assert property (reg_wr_in && reg_addr_in == ADDR_SCANNING
    && !ee_done_in |=> scan_on_axis_out
    == (($past(reg_wdata_in) & (8'h01 << BIT_ON_AXIS)) != 8'h00))
    else $error("on-axis output differs from written value");
  a_diff_select: assert property (scan_differential_out == (scan_on_axis_out ?
    pole_size_select_out == 2'h1 : pole_size_select_out == 2'h0))
    else $error("differential select wrong");
  a_ee_pulse: assert property (ee_req_out |=> !ee_req_out)
    else $error("eeprom request longer than one cycle");
  a_serial_mode: assert property (serial_readout_out |-> mode_out inside {2'h0, 2'h1})
    else $error("serial readout outside serial modes");
  a_idle_par: assert property (low_power_idle_out |-> mode_out == MODE_PARALLEL)
    else $error("idle outside parallel mode");
  a_wr_visible: assert property (reg_wr_in && reg_addr_in == ADDR_PHASE_OFFSET
    && !ee_done_in
    |=> reg_addr_in != ADDR_PHASE_OFFSET || reg_rdata_out == $past(reg_wdata_in))
    else $error("offset write not visible");
  cover property ($rose(twowire_readout_out));
  cover property ($rose(low_power_idle_out));
  cover property ($fell(error_output_n_out));
endmodule : ebp_top_assertions

bind ebp_top ebp_top_assertions u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .ee_done_in(ee_done_in),
  .status_clear_command_in(status_clear_command_in), .battery_error_in(battery_error_in),
  .battery_error_out(battery_error_out), .ee_req_out(ee_req_out),
  .error_output_n_out(error_output_n_out), .mode_out(mode_out),
  .serial_readout_out(serial_readout_out), .twowire_readout_out(twowire_readout_out),
  .slave_addr_out(slave_addr_out), .low_power_idle_out(low_power_idle_out),
  .scan_differential_out(scan_differential_out), .scan_on_axis_out(scan_on_axis_out),
  .pole_size_select_out(pole_size_select_out), .parallel_p_out(parallel_p_out),
  .parallel_n_out(parallel_n_out));

// File: testbench/ebp_ee_model.sv
// Configuration EEPROM reader model answering byte requests.
// Assumes one request in flight; fails byte 2 of the first attempts.
module ebp_ee_model
  import ebp_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       ee_req_in,
  input  wire logic [2:0] ee_addr_in,
  input  wire logic [7:0] cfg0_in,
  input  wire logic [1:0] fail_count_in,
  input  wire logic       slow_in,
  output logic            ee_done_out,
  output logic            ee_fail_out,
  output logic      [7:0] ee_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_reg;
  logic [3:0] wait_reg;
  logic [1:0] fails_reg;
  logic [2:0] addr_reg;
  function automatic logic [7:0] cfg_byte(input logic [2:0] a);
    case (a)
      3'h0:    cfg_byte = cfg0_in;
      3'h1:    cfg_byte = 8'h1F;
      3'h2:    cfg_byte = 8'h01;
      3'h4:    cfg_byte = 8'h02;
      3'h5:    cfg_byte = 8'h40;
      default: cfg_byte = 8'h00;
    endcase
  endfunction : cfg_byte
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_reg    <= 1'b0;
      wait_reg    <= 4'h0;
      fails_reg   <= 2'h0;
      addr_reg    <= 3'h0;
      ee_done_out <= 1'b0;
      ee_fail_out <= 1'b0;
      ee_data_out <= 8'hA5;
    end else begin
      ee_done_out <= 1'b0;
      ee_fail_out <= 1'b0;
      // Released data line shows no stale value
      ee_data_out <= ~ee_data_out;
      if (ee_req_in) begin
        busy_reg <= 1'b1;
        wait_reg <= slow_in ? 4'h6 : 4'h0;
        addr_reg <= ee_addr_in;
      end else if (busy_reg && wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg    <= 1'b0;
        ee_done_out <= 1'b1;
        ee_data_out <= cfg_byte(addr_reg);
        if (addr_reg == 3'h2 && fails_reg < fail_count_in) begin
          ee_fail_out <= 1'b1;
          fails_reg   <= fails_reg + 2'h1;
        end
      end
    end
  end
endmodule : ebp_ee_model

// File: testbench/tb_top.sv
// Testbench for the encoder boot/position top with an EEPROM model.
// Inputs change at the falling clock edge.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ebp_pkg::*;
  logic        clk, rst_n, sel_hi, sel_tp, pre, wr, status_clear_command, batt, rdone, slow;
  logic [2:0]  hall, addr;
  logic [7:0]  wdata, cfg0;
  logic [1:0]  nfail;
  wire  [7:0]  rdata, ee_data;
  wire  [2:0]  ee_addr, pos, pp, pn;
  wire  [1:0]  mode, pole;
  wire  [6:0]  saddr;
  wire  [39:0] mt;
  wire         berr, ee_req, ee_done, ee_fail, err_n, ser, twr, sen, idle, sdiff, sonax;
  int          n_mismatch, num_checks, n_req;

  ebp_top dut (.clk_sys_in(clk), .reset_n_in(rst_n), .sel_high_in(sel_hi),
    .sel_tied_preset_in(sel_tp), .preset_in(pre), .hall_in(hall), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .status_clear_command_in(status_clear_command), .battery_error_in(batt), .battery_error_out(berr),
    .ee_req_out(ee_req), .ee_addr_out(ee_addr), .ee_done_in(ee_done), .ee_fail_in(ee_fail),
    .ee_data_in(ee_data), .readout_done_in(rdone), .error_output_n_out(err_n),
    .mode_out(mode), .serial_readout_out(ser), .twowire_readout_out(twr),
    .slave_addr_out(saddr), .slave_enable_out(sen), .low_power_idle_out(idle),
    .scan_differential_out(sdiff), .scan_on_axis_out(sonax), .pole_size_select_out(pole),
    .position_out(pos), .parallel_p_out(pp), .parallel_n_out(pn), .multiturn_out(mt));
  ebp_ee_model u_ee (.clk_sys_in(clk), .reset_n_in(rst_n), .ee_req_in(ee_req),
    .ee_addr_in(ee_addr), .cfg0_in(cfg0), .fail_count_in(nfail), .slow_in(slow),
    .ee_done_out(ee_done), .ee_fail_out(ee_fail), .ee_data_out(ee_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) if (ee_req === 1'b1) n_req++;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic boot(input logic hi, tp, input logic [7:0] c0, input logic [1:0] nf,
                      input logic s);
    int i;
    rst_n = 1'b0; sel_hi = hi; sel_tp = tp; cfg0 = c0; nfail = nf; slow = s;
    pre = 1'b0; wr = 1'b0; status_clear_command = 1'b0; batt = 1'b0; rdone = 1'b0; hall = 3'h0;
    cyc(3);
    rst_n = 1'b1;
    n_req = 0;
    cyc(2);
    pre = 1'b1;
    cyc(3);
    pre = 1'b0;
    for (i = 0; i < 400 && err_n !== 1'b0 && ser !== 1'b1 && twr !== 1'b1 && mode === 2'h0;
         i++) cyc(1);
  endtask : boot
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wreg
  task automatic rreg(input string nm, input logic [2:0] a, input logic [7:0] e);
    addr = a;
    #1 chk(nm, {32'h0, e}, {32'h0, rdata});
    cyc(1);
  endtask : rreg

  task automatic t_serial;
    boot(1'b0, 1'b0, 8'h00, 2'h0, 1'b0);
    chk("mode", MODE_SERIAL, mode);
    chk("routing", 2'b10, {ser, twr});
    chk("slave enable", 1, sen);
    chk("requests", 6, n_req);
    rreg("offset reg", ADDR_PHASE_OFFSET, 8'h1F);
    rreg("periods reg", ADDR_PERIODS_REV, 8'h01);
    rreg("unmapped", 3'h3, 8'h00);
    rreg("scan reg", ADDR_SCANNING, 8'h02);
    rreg("options reg", ADDR_OUTPUT_OPTIONS, 8'h40);
    chk("pole", {POLE_SE_2_4, 1'b0}, {pole, sdiff});
    batt = 1'b1; cyc(1); batt = 1'b0; cyc(6);
    chk("battery set", 2'b10, {berr, err_n});
    status_clear_command = 1'b1; cyc(1); status_clear_command = 1'b0; cyc(6);
    chk("battery clear", 2'b01, {berr, err_n});
    $display("test serial done");
  endtask : t_serial
  task automatic t_retry;
    boot(1'b0, 1'b0, 8'h01, 2'h2, 1'b1);
    chk("mode", MODE_CHAIN, mode);
    chk("slave enable", 0, sen);
    chk("error pin", 1, err_n);
    chk("requests", 12, n_req);
    boot(1'b0, 1'b0, 8'h00, 2'h3, 1'b0);
    cyc(50);
    chk("error pin", 0, err_n);
    chk("requests", 9, n_req);
    chk("routing", 0, ser);
    $display("test retry done");
  endtask : t_retry
  task automatic t_slave_par;
    boot(1'b0, 1'b1, 8'h00, 2'h0, 1'b0);
    chk("mode", MODE_SLAVE, mode);
    chk("routing", 2'b10, {twr, ser});
    chk("slave enable", 1, sen);
    chk("requests", 0, n_req);
    chk("address", 7'h61, saddr);
    boot(1'b1, 1'b0, 8'h00, 2'h0, 1'b0);
    chk("mode", MODE_PARALLEL, mode);
    chk("idle", 0, idle);
    rdone = 1'b1; cyc(1); rdone = 1'b0; cyc(6);
    chk("idle", 1, idle);
    pre = 1'b1; cyc(3); pre = 1'b0; cyc(6);
    chk("idle", 0, idle);
    $display("test slave and parallel done");
  endtask : t_slave_par
  task automatic t_pos;
    logic [2:0] e;
    boot(1'b0, 1'b0, 8'h00, 2'h0, 1'b0);
    for (int d = 0; d < 2; d++) begin
      for (int o = 0; o < 8; o++) begin
        wreg(ADDR_IFACE_DIR, 8'(d * 8));
        wreg(ADDR_PHASE_OFFSET, 8'(o * 32));
        for (int h = 0; h < 8; h++) begin
          hall = 3'(h);
          cyc(7);
          e = (d != 0 ? 3'(8 - h) : 3'(h)) + 3'(o);
          chk("position", e, pp);
          chk("complement", 3'(~e), pn);
        end
      end
    end
    $display("test position done");
  endtask : t_pos
  task automatic t_scan_count;
    logic [1:0] p;
    boot(1'b0, 1'b0, 8'h00, 2'h0, 1'b0);
    for (int i = 1; i <= 16; i++) begin
      hall = 3'(i);
      cyc(8);
    end
    chk("index out", 40'h100, mt);
    wreg(ADDR_OUTPUT_OPTIONS, 8'h00);
    chk("count", 40'h1, mt);
    hall = 3'h7;
    cyc(8);
    chk("count back", 40'h0, mt);
    chk("sector", 3'h7, pos);
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_SCANNING, 8'(c));
      p = 2'(c);
      chk("scan", {p, c[2], c[2] ? p == 2'h1 : p == 2'h0}, {pole, sonax, sdiff});
    end
    $display("test scan and count done");
  endtask : t_scan_count

  initial begin
    addr = 3'h0; wdata = 8'h00;
    t_serial;
    t_retry;
    t_slave_par;
    t_pos;
    t_scan_count;
    finish_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
endmodule : tb_top
